// ### serial_port_config_regs.sv
`include "serial_port_defs.svh"

module serial_port_config_regs
    import serial_port_pkg::*;
#(
    parameter reg_byte_t VARIANT_ID = 8'h5a, // Arbitrary identification value
    parameter int GENERAL_COUNT = 4
)(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire reg_addr_t ADDR,
    input wire reg_byte_t WR_DATA,
    output reg_byte_t RD_DATA,
    output logic RD_VALID,
    output logic LSB_FIRST,
    output logic ADDR_INCREMENT,
    output logic SEPARATE_OUTPUT_ENABLE,
    output logic LONG_INSTRUCTION,
    output logic SOFT_RESET_ACTIVE,
    output logic [8*GENERAL_COUNT-1:0] ACTIVE_REGS
);
    localparam int SHADOW_COUNT = GENERAL_COUNT + 1;

    reg_byte_t config_reg;
    reg_byte_t next_config_reg;
    reg_byte_t next_rd_data;
    logic next_rd_valid;
    logic restore;
    logic update;
    logic hit_config;
    logic hit_ident;
    logic hit_update;
    logic hit_any_shadow;
    logic sel_active;
    logic [SHADOW_COUNT-1:0] hit_shadow;
    logic [SHADOW_COUNT-1:0] shadow_wr;
    reg_byte_t shadow_buffer [SHADOW_COUNT];
    reg_byte_t shadow_active [SHADOW_COUNT];
    reg_byte_t shadow_pick;

    // Address of buffered slot k: slot 0 is the readback select, the rest general
    function automatic reg_addr_t shadow_wr_addr(input int k);
        reg_addr_t a;
        if (k == 0)
            a = `OFS_READBACK_SOURCE_SELECT;
        else
            a = `OFS_GENERAL_BASE + reg_addr_t'(k - 1);
        return a;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode, shared by the write and read paths

    assign hit_config = (ADDR == `OFS_SERIAL_PORT_CONFIG);
    assign hit_ident = (ADDR == `OFS_VARIANT_IDENTIFIER);
    assign hit_update = (ADDR == `OFS_UPDATE_ALL);
    assign hit_any_shadow = |hit_shadow;
    // Reads steer by the active select, so a new select waits for an update
    assign sel_active = shadow_active[0][`READBACK_ACTIVE_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Serial port configuration, applied at once so the port keeps talking

    assign restore = config_reg[`CFG_SOFT_RESET_BIT];
    assign update = WR_EN && hit_update && WR_DATA[`UPDATE_ALL_BIT];

    always_comb
    begin
        next_config_reg = config_reg;
        // A write in a soft reset cycle wins, else the host could never clear it
        if (WR_EN && hit_config)
            next_config_reg = WR_DATA;
        else if (restore)
        begin
            // Defaults come back but the reset bit and its mirror hold until cleared
            next_config_reg = `RST_SERIAL_PORT_CONFIG;
            next_config_reg[`CFG_SOFT_RESET_BIT] = 1'b1;
            next_config_reg[`CFG_SOFT_MIRROR_BIT] = 1'b1;
        end
        next_config_reg[`CFG_LONG_INSTR_BIT] = 1'b1;
        next_config_reg[`CFG_LONG_MIRROR_BIT] = 1'b1;
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            config_reg <= `RST_SERIAL_PORT_CONFIG;
        else
            config_reg <= next_config_reg;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status outputs, straight from the configuration flops
    // Order and stepping share one bit, so they can never disagree

    assign LSB_FIRST = config_reg[`CFG_LSB_FIRST_BIT];
    assign ADDR_INCREMENT = config_reg[`CFG_LSB_FIRST_BIT];
    assign SEPARATE_OUTPUT_ENABLE = config_reg[`CFG_BIDIR_SEL_BIT];
    assign LONG_INSTRUCTION = config_reg[`CFG_LONG_INSTR_BIT];
    assign SOFT_RESET_ACTIVE = config_reg[`CFG_SOFT_RESET_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Buffered registers: slot 0 is the readback select, the rest general

    genvar i;
    generate
        for (i = 0; i < SHADOW_COUNT; i++)
        begin : g_shadow
            assign hit_shadow[i] = (ADDR == shadow_wr_addr(i));
            if (i == 0)
            begin : g_sel
                assign shadow_wr[i] = WR_EN && hit_shadow[i];
            end
            else
            begin : g_gen
                assign shadow_wr[i] = WR_EN && hit_shadow[i];
                assign ACTIVE_REGS[8*(i-1) +: 8] = shadow_active[i];
            end
            shadow_reg #(
                .RESET_VALUE((i == 0) ? `RST_READBACK_SOURCE_SELECT : `RST_GENERAL)
            ) u_shadow (
                .clk(MCLK),
                .rst(RST),
                .restore(restore),
                .wr_en(shadow_wr[i]),
                .wr_data(WR_DATA),
                .update(update),
                .buffer(shadow_buffer[i]),
                .active(shadow_active[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Readback

    // The select's active copy steers every buffered slot, itself included
    always_comb
    begin
        shadow_pick = 8'h00;
        for (int k = 0; k < SHADOW_COUNT; k++)
        begin
            if (hit_shadow[k])
            begin
                if (sel_active)
                    shadow_pick = shadow_active[k];
                else
                    shadow_pick = shadow_buffer[k];
            end
        end
    end

    always_comb
    begin
        next_rd_data = 8'h00;
        next_rd_valid = RD_EN;
        if (RD_EN)
        begin
            if (hit_config)
                next_rd_data = config_reg;
            else if (hit_ident)
                next_rd_data = VARIANT_ID;
            else if (hit_any_shadow)
                next_rd_data = shadow_pick;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            RD_DATA <= 8'h00;
            RD_VALID <= 1'b0;
        end
        else
        begin
            RD_DATA <= next_rd_data;
            RD_VALID <= next_rd_valid;
        end
    end
endmodule // serial_port_config_regs

// ### serial_port_defs.svh
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

`define ADDR_W 10
`define OFS_SERIAL_PORT_CONFIG 10'h000
`define OFS_VARIANT_IDENTIFIER 10'h003
`define OFS_READBACK_SOURCE_SELECT 10'h004
`define OFS_GENERAL_BASE 10'h010
`define OFS_UPDATE_ALL 10'h232

`define CFG_BIDIR_SEL_BIT 0
`define CFG_LSB_FIRST_BIT 1
`define CFG_SOFT_RESET_BIT 2
`define CFG_LONG_INSTR_BIT 3
`define CFG_LONG_MIRROR_BIT 4
`define CFG_SOFT_MIRROR_BIT 5
`define READBACK_ACTIVE_BIT 0
`define UPDATE_ALL_BIT 0

`define RST_SERIAL_PORT_CONFIG 8'h18
`define RST_READBACK_SOURCE_SELECT 8'h00
`define RST_GENERAL 8'h00

`endif

// ### serial_port_pkg.sv
package serial_port_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [9:0] reg_addr_t;
endpackage

// ### shadow_reg.sv
`include "serial_port_defs.svh"

// One register with a buffer copy written by the host and an active copy in use
module shadow_reg
    import serial_port_pkg::*;
#(
    parameter reg_byte_t RESET_VALUE = `RST_GENERAL
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic restore,
    input wire logic wr_en,
    input wire reg_byte_t wr_data,
    input wire logic update,
    output reg_byte_t buffer,
    output reg_byte_t active
);
    reg_byte_t next_buffer;
    reg_byte_t next_active;

    always_comb
    begin
        next_buffer = buffer;
        next_active = active;
        if (restore)
        begin
            next_buffer = RESET_VALUE;
            next_active = RESET_VALUE;
        end
        else
        begin
            if (wr_en)
                next_buffer = wr_data;
            if (update)
                next_active = wr_en ? wr_data : buffer;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            buffer <= RESET_VALUE;
            active <= RESET_VALUE;
        end
        else
        begin
            buffer <= next_buffer;
            active <= next_active;
        end
    end
endmodule // shadow_reg

// ### spc_checker_assertions.sv
module spc_checker
    import serial_port_pkg::*;
#(
    parameter reg_byte_t VARIANT_ID = 8'h5a
)(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire reg_addr_t ADDR,
    input wire reg_byte_t WR_DATA,
    input wire reg_byte_t RD_DATA,
    input wire logic RD_VALID,
    input wire logic LSB_FIRST,
    input wire logic ADDR_INCREMENT,
    input wire logic SEPARATE_OUTPUT_ENABLE,
    input wire logic LONG_INSTRUCTION,
    input wire logic SOFT_RESET_ACTIVE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    wire cfg_wr = WR_EN && ADDR == 10'h000;
    chk_long_fixed: assert property (LONG_INSTRUCTION)
        else $error("long mode lost");
    chk_dir_pair: assert property (LSB_FIRST == ADDR_INCREMENT)
        else $error("order and stepping differ");
    chk_dir_write: assert property (cfg_wr |=> LSB_FIRST == $past(WR_DATA[1]))
        else $error("order not written");
    chk_dir_hold: assert property (!cfg_wr && !SOFT_RESET_ACTIVE |=> $stable(LSB_FIRST))
        else $error("order changed");
    chk_pin_write: assert property (cfg_wr |=> SEPARATE_OUTPUT_ENABLE == $past(WR_DATA[0]))
        else $error("pin mode not written");
    chk_srst_write: assert property (cfg_wr |=> SOFT_RESET_ACTIVE == $past(WR_DATA[2]))
        else $error("soft reset not written");
    chk_srst_hold: assert property (SOFT_RESET_ACTIVE && !cfg_wr |=> SOFT_RESET_ACTIVE)
        else $error("soft reset cleared itself");
    chk_srst_defaults: assert property (SOFT_RESET_ACTIVE && !cfg_wr
        |=> !LSB_FIRST && !SEPARATE_OUTPUT_ENABLE)
        else $error("defaults not restored");
    chk_id_read: assert property (RD_EN && ADDR == 10'h003 |=> RD_DATA == VARIANT_ID)
        else $error("bad identifier");
    chk_rd_pulse: assert property (RD_EN |=> RD_VALID)
        else $error("read not answered");
    chk_rd_idle: assert property (!RD_EN |=> !RD_VALID && RD_DATA == 8'h00)
        else $error("read data without a read");
    chk_upd_clear: assert property (RD_EN && ADDR == 10'h232 |=> RD_DATA == 8'h00)
        else $error("update bit stored");
    chk_long_read: assert property (RD_EN && ADDR == 10'h000 |=> RD_DATA[3] && RD_DATA[4])
        else $error("long mode bits read low");
endmodule // spc_checker

// ### spc_host.sv
module spc_host
    import serial_port_pkg::*;
(
    input wire logic MCLK,
    input wire reg_byte_t RD_DATA,
    input wire logic RD_VALID,
    output logic WR_EN = 1'b0,
    output logic RD_EN = 1'b0,
    output reg_addr_t ADDR = '0,
    output reg_byte_t WR_DATA = '0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic xfer(input logic w, input reg_addr_t a, input reg_byte_t d,
        output reg_byte_t q);
        @(posedge MCLK);
        #1 WR_EN = w;
        RD_EN = !w;
        ADDR = a;
        WR_DATA = d;
        @(posedge MCLK);
        #1 WR_EN = 0;
        RD_EN = 0;
        q = RD_VALID ? RD_DATA : 'x;
        // Released lines flip so a stale value cannot pass for a fresh one
        ADDR = ~a;
        WR_DATA = ~d;
    endtask
endmodule // spc_host

// ### tb.sv
module tb
    import serial_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK = 0, RST = 1, WR_EN, RD_EN, RD_VALID, LSB_FIRST, ADDR_INCREMENT;
    logic SEPARATE_OUTPUT_ENABLE, LONG_INSTRUCTION, SOFT_RESET_ACTIVE;
    reg_addr_t ADDR;
    reg_byte_t WR_DATA, RD_DATA, q, r;
    reg_byte_t act [4] = '{default: 8'h00};
    logic [1:0] k;
    logic [31:0] ACTIVE_REGS, seed = 32'hb4da53d3;
    int error_cnt = 0, num_checks = 0;
    always #2.5 MCLK = ~MCLK;
    serial_port_config_regs i_serial_port_config_regs (
        .MCLK(MCLK),
        .RST(RST),
        .WR_EN(WR_EN),
        .RD_EN(RD_EN),
        .ADDR(ADDR),
        .WR_DATA(WR_DATA),
        .RD_DATA(RD_DATA),
        .RD_VALID(RD_VALID),
        .LSB_FIRST(LSB_FIRST),
        .ADDR_INCREMENT(ADDR_INCREMENT),
        .SEPARATE_OUTPUT_ENABLE(SEPARATE_OUTPUT_ENABLE),
        .LONG_INSTRUCTION(LONG_INSTRUCTION),
        .SOFT_RESET_ACTIVE(SOFT_RESET_ACTIVE),
        .ACTIVE_REGS(ACTIVE_REGS)
    );
    spc_host host (
        .MCLK(MCLK),
        .RD_DATA(RD_DATA),
        .RD_VALID(RD_VALID),
        .WR_EN(WR_EN),
        .RD_EN(RD_EN),
        .ADDR(ADDR),
        .WR_DATA(WR_DATA)
    );
    function automatic reg_byte_t mir(input logic [3:0] n);
        return {n[0], n[1], n[2], n[3], n};
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #20000;
        error_cnt++;
        end_sim;
    end
    initial
    begin
        repeat (16) @(posedge MCLK);
        #1 RST = 0;
        host.xfer(0, 10'h000, 0, q);
        chk("cfg", q, 8'h18);
        host.xfer(1, 10'h003, 8'ha5, q);
        host.xfer(0, 10'h003, 0, q);
        chk("id", q, 8'h5a);
        for (int b = 0; b < 4; b++)
        begin
            host.xfer(1, 10'h000, mir(4'h8 | b[3:0]), q);
            host.xfer(0, 10'h000, 0, q);
            chk("cfg", q, mir(4'h8 | b[3:0]));
            chk("mode", {LSB_FIRST, ADDR_INCREMENT, SEPARATE_OUTPUT_ENABLE},
                {b[1], b[1], b[0]});
        end
        for (int i = 0; i < 16; i++)
        begin
            seed = xs(seed);
            r = seed[7:0];
            k = seed[9:8];
            host.xfer(1, 10'h010 + k, r, q);
            chk("act", ACTIVE_REGS, {act[3], act[2], act[1], act[0]});
            host.xfer(0, 10'h010 + k, 0, q);
            chk("rdbk", q, i > 7 ? act[k] : r);
            if (i == 7)
                host.xfer(1, 10'h004, 8'h01, q);
            host.xfer(1, 10'h232, 8'h01, q);
            act[k] = r;
            chk("upd", ACTIVE_REGS, {act[3], act[2], act[1], act[0]});
        end
        host.xfer(1, 10'h010, ~act[0], q);
        host.xfer(1, 10'h232, 8'hfe, q);
        chk("hold", ACTIVE_REGS, {act[3], act[2], act[1], act[0]});
        host.xfer(0, 10'h232, 0, q);
        chk("upd", q, 0);
        host.xfer(1, 10'h000, mir(4'hc), q);
        host.xfer(0, 10'h000, 0, q);
        chk("srst", q, mir(4'hc));
        chk("dflt", {ACTIVE_REGS, LSB_FIRST}, 0);
        host.xfer(1, 10'h000, mir(4'h8), q);
        chk("done", SOFT_RESET_ACTIVE, 0);
        host.xfer(0, 10'h010, 0, q);
        chk("dflt", q, 0);
        host.xfer(0, 10'h004, 0, q);
        chk("dflt", q, 0);
        end_sim;
    end
endmodule // tb
bind serial_port_config_regs spc_checker #(.VARIANT_ID(VARIANT_ID)) i_chk (
    .MCLK(MCLK),
    .RST(RST),
    .WR_EN(WR_EN),
    .RD_EN(RD_EN),
    .ADDR(ADDR),
    .WR_DATA(WR_DATA),
    .RD_DATA(RD_DATA),
    .RD_VALID(RD_VALID),
    .LSB_FIRST(LSB_FIRST),
    .ADDR_INCREMENT(ADDR_INCREMENT),
    .SEPARATE_OUTPUT_ENABLE(SEPARATE_OUTPUT_ENABLE),
    .LONG_INSTRUCTION(LONG_INSTRUCTION),
    .SOFT_RESET_ACTIVE(SOFT_RESET_ACTIVE)
);
